// File: src/lsag_defs.vh
// constants for the load/store address generator
`ifndef LSAG_DEFS_VH
`define LSAG_DEFS_VH

// ***********************************************************************
// addressing modes
// ***********************************************************************
`define LSAG_MODE_ABS 3'h0
`define LSAG_MODE_BSO 3'h1
`define LSAG_MODE_BLO 3'h2
`define LSAG_MODE_PRE 3'h3
`define LSAG_MODE_POST 3'h4
`define LSAG_MODE_CIRC 3'h5
`define LSAG_MODE_BREV 3'h6

// ***********************************************************************
// access sizes
// ***********************************************************************
`define LSAG_SIZE_BIT 3'h0
`define LSAG_SIZE_BYTE 3'h1
`define LSAG_SIZE_HALF 3'h2
`define LSAG_SIZE_WORD 3'h3
`define LSAG_SIZE_DWORD 3'h4

// ***********************************************************************
// address field layout
// ***********************************************************************
`define LSAG_SEG_HI 31
`define LSAG_SEG_LO 28
`define LSAG_ABS_LOW_W 14

// ***********************************************************************
// register map
// ***********************************************************************
`define LSAG_REG_CTRL 8'h00
`define LSAG_REG_STATUS 8'h04
`define LSAG_REG_MASK 8'h08
`define LSAG_REG_COUNT 8'h0C
`define LSAG_REG_LAST_EA 8'h10

// ***********************************************************************
// field positions and reset values
// ***********************************************************************
`define LSAG_CTRL_EN 0
`define LSAG_ST_ALIGN 0
`define LSAG_ST_SEG 1
`define LSAG_ST_WRAP 2
`define LSAG_CTRL_RST 1'h1
`define LSAG_MASK_RST 3'h0

`endif

// File: src/lsag_top.v
// load/store effective address generator with register port and interrupt

`include "lsag_defs.vh"

// Contract
// - seven modes; absolute, single register, register pair
// - access sizes bit, byte, half, word, dword
// - absolute: top four bits to 31..28
// - base plus sign-extended offset, no write-back
// - pre-increment: sum is address and write-back
// - post-increment: old register address, write sum
// - circular: even base, odd length and index
// - circular address is base plus index
// - circular index wraps by adding or subtracting length
// - circular access past end continues at base
// - circular base or length misaligned traps
// - bit-reverse: even base, odd modifier and index
// - bit-reverse address is base plus index
// - index becomes rev(rev(I) plus rev(M))
// - displacement crossing segment boundary traps, except in post-increment
// - bytes assembled little-endian, also across wrap
module lsag_top (
	input wire sys_clk,
	input wire rstn,
	input wire req_valid,
	input wire [2:0] req_mode,
	input wire [2:0] req_size,
	input wire [17:0] req_imm,
	input wire [31:0] areg_even,
	input wire [31:0] areg_odd,
	output reg ans_valid,
	output reg [31:0] ans_addr,
	output reg ans_split,
	output reg [31:0] ans_wrap_addr,
	output reg [3:0] ans_first_bytes,
	output reg ans_wb_en,
	output reg ans_wb_odd,
	output reg [31:0] ans_wb_data,
	output reg ans_trap_align,
	output reg ans_trap_seg,
	input wire [7:0] bus_addr,
	input wire [31:0] bus_wdata,
	input wire bus_wr,
	input wire bus_rd,
	output reg [31:0] bus_rdata,
	output reg irq
);

	// ***********************************************************************
	// helper functions
	// ***********************************************************************
	function [31:0] sext10;
		input [9:0] v;
		begin
			sext10 = {{22{v[9]}}, v};
		end
	endfunction

	function [15:0] rev16;
		input [15:0] v;
		integer n;
		begin
			for (n = 0; n < 16; n = n + 1) begin
				rev16[n] = v[15 - n];
			end
		end
	endfunction

	// bit accesses occupy one byte for alignment and wrap purposes
	function [3:0] size_bytes;
		input [2:0] sz;
		begin
			case (sz)
				`LSAG_SIZE_BIT: size_bytes = 4'h1;
				`LSAG_SIZE_BYTE: size_bytes = 4'h1;
				`LSAG_SIZE_HALF: size_bytes = 4'h2;
				`LSAG_SIZE_WORD: size_bytes = 4'h4;
				`LSAG_SIZE_DWORD: size_bytes = 4'h8;
				default: size_bytes = 4'h1;
			endcase
		end
	endfunction

	// low bits that must be zero for an aligned value of this size
	function [2:0] size_mask;
		input [2:0] sz;
		begin
			case (sz)
				`LSAG_SIZE_HALF: size_mask = 3'h1;
				`LSAG_SIZE_WORD: size_mask = 3'h3;
				`LSAG_SIZE_DWORD: size_mask = 3'h7;
				default: size_mask = 3'h0;
			endcase
		end
	endfunction

	function seg_cross;
		input [31:0] base;
		input [31:0] sum;
		begin
			seg_cross = base[`LSAG_SEG_HI:`LSAG_SEG_LO] != sum[`LSAG_SEG_HI:`LSAG_SEG_LO];
		end
	endfunction

	// ***********************************************************************
	// register state
	// ***********************************************************************
	reg ctrl_en_r;
	reg [2:0] status_r;
	reg [2:0] status_nxt;
	reg [2:0] mask_r;
	reg [31:0] count_r;
	reg [31:0] last_ea_r;

	// ***********************************************************************
	// operand fields
	// ***********************************************************************
	wire [3:0] nbytes;
	wire [2:0] amask;
	wire [31:0] off10;
	wire [31:0] off16;
	wire [15:0] buf_len;
	wire [15:0] idx;
	wire [15:0] brev_mod;
	wire [31:0] sum10;
	wire [31:0] sum16;
	wire [31:0] base_idx;

	assign nbytes = size_bytes(req_size);
	assign amask = size_mask(req_size);
	assign off10 = sext10(req_imm[9:0]);
	assign off16 = {{16{req_imm[15]}}, req_imm[15:0]};
	assign buf_len = areg_odd[31:16];
	assign idx = areg_odd[15:0];
	assign brev_mod = areg_odd[31:16];
	assign sum10 = areg_even + off10;
	assign sum16 = areg_even + off16;
	assign base_idx = areg_even + {16'h0000, idx};

	// ***********************************************************************
	// circular index update
	// ***********************************************************************
	wire [17:0] circ_tmp;
	wire circ_neg;
	wire circ_ge;
	wire [17:0] circ_add;
	wire [17:0] circ_sub;
	wire [15:0] circ_idx_new;
	wire [16:0] circ_end;
	wire circ_split;
	wire [15:0] circ_room;

	// eighteen bits keep the sign of index plus offset unambiguous
	assign circ_tmp = {2'b00, idx} + {{8{req_imm[9]}}, req_imm[9:0]};
	assign circ_neg = circ_tmp[17];
	assign circ_ge = !circ_neg && (circ_tmp[16:0] >= {1'b0, buf_len});
	assign circ_add = circ_tmp + {2'b00, buf_len};
	assign circ_sub = circ_tmp - {2'b00, buf_len};
	// wrap holds only while offset magnitude stays below length
	assign circ_idx_new = circ_neg ? circ_add[15:0] :
		(circ_ge ? circ_sub[15:0] : circ_tmp[15:0]);
	assign circ_end = {1'b0, idx} + {13'h0000, nbytes};
	assign circ_split = circ_end > {1'b0, buf_len};
	assign circ_room = buf_len - idx;

	// ***********************************************************************
	// bit-reverse index update
	// ***********************************************************************
	wire [15:0] brev_sum;
	wire [15:0] brev_idx_new;

	// carry out of the reversed sum is dropped
	assign brev_sum = rev16(idx) + rev16(brev_mod);
	assign brev_idx_new = rev16(brev_sum);

	// ***********************************************************************
	// mode decode
	// ***********************************************************************
	reg [31:0] ea_nxt;
	reg split_nxt;
	reg [3:0] first_nxt;
	reg wb_nxt;
	reg wb_odd_nxt;
	reg [31:0] wb_data_nxt;
	reg t_align_nxt;
	reg t_seg_nxt;

	always @* begin
		ea_nxt = 32'h00000000;
		split_nxt = 1'b0;
		first_nxt = nbytes;
		wb_nxt = 1'b0;
		wb_odd_nxt = 1'b0;
		wb_data_nxt = 32'h00000000;
		t_align_nxt = 1'b0;
		t_seg_nxt = 1'b0;
		case (req_mode)
			`LSAG_MODE_ABS: begin
				ea_nxt = {req_imm[17:14], 14'h0000, req_imm[13:0]};
			end
			`LSAG_MODE_BSO: begin
				ea_nxt = sum10;
				t_seg_nxt = seg_cross(areg_even, sum10);
			end
			`LSAG_MODE_BLO: begin
				ea_nxt = sum16;
				t_seg_nxt = seg_cross(areg_even, sum16);
			end
			`LSAG_MODE_PRE: begin
				ea_nxt = sum10;
				wb_nxt = 1'b1;
				wb_data_nxt = sum10;
				t_seg_nxt = seg_cross(areg_even, sum10);
			end
			`LSAG_MODE_POST: begin
				ea_nxt = areg_even;
				wb_nxt = 1'b1;
				wb_data_nxt = sum10;
			end
			`LSAG_MODE_CIRC: begin
				ea_nxt = base_idx;
				wb_nxt = 1'b1;
				wb_odd_nxt = 1'b1;
				wb_data_nxt = {buf_len, circ_idx_new};
				// first part fills the low bytes, the rest from base above it
				split_nxt = circ_split;
				first_nxt = circ_split ? circ_room[3:0] : nbytes;
				t_align_nxt = ((areg_even[2:0] & amask) != 3'h0) ||
					((buf_len[2:0] & amask) != 3'h0);
				t_seg_nxt = seg_cross(areg_even, base_idx);
			end
			`LSAG_MODE_BREV: begin
				ea_nxt = base_idx;
				wb_nxt = 1'b1;
				wb_odd_nxt = 1'b1;
				wb_data_nxt = {brev_mod, brev_idx_new};
				t_seg_nxt = seg_cross(areg_even, base_idx);
			end
			default: begin
				ea_nxt = 32'h00000000;
			end
		endcase
	end

	// ***********************************************************************
	// answer stage
	// ***********************************************************************
	wire take;
	wire trap_any;

	assign take = req_valid && ctrl_en_r;
	assign trap_any = t_align_nxt || t_seg_nxt;

	always @(posedge sys_clk) begin
		if (!rstn) begin
			ans_valid <= 1'b0;
			ans_addr <= 32'h00000000;
			ans_split <= 1'b0;
			ans_wrap_addr <= 32'h00000000;
			ans_first_bytes <= 4'h0;
			ans_wb_en <= 1'b0;
			ans_wb_odd <= 1'b0;
			ans_wb_data <= 32'h00000000;
			ans_trap_align <= 1'b0;
			ans_trap_seg <= 1'b0;
		end else begin
			ans_valid <= take;
			if (take) begin
				ans_addr <= ea_nxt;
				ans_split <= split_nxt;
				ans_wrap_addr <= areg_even;
				ans_first_bytes <= first_nxt;
				// a trapped access must not disturb the address registers
				ans_wb_en <= wb_nxt && !trap_any;
				ans_wb_odd <= wb_odd_nxt;
				ans_wb_data <= wb_data_nxt;
				ans_trap_align <= t_align_nxt;
				ans_trap_seg <= t_seg_nxt;
			end else begin
				ans_wb_en <= 1'b0;
				ans_split <= 1'b0;
				ans_trap_align <= 1'b0;
				ans_trap_seg <= 1'b0;
			end
		end
	end

	// ***********************************************************************
	// register port and interrupt
	// ***********************************************************************
	wire wr_ctrl;
	wire wr_status;
	wire wr_mask;
	wire [2:0] st_set;

	assign wr_ctrl = bus_wr && (bus_addr == `LSAG_REG_CTRL);
	assign wr_status = bus_wr && (bus_addr == `LSAG_REG_STATUS);
	assign wr_mask = bus_wr && (bus_addr == `LSAG_REG_MASK);
	assign st_set = {take && split_nxt, take && t_seg_nxt, take && t_align_nxt};

	// a new event beats a same-cycle write-one clear
	always @* begin
		status_nxt = status_r;
		if (wr_status) begin
			status_nxt = status_r & ~bus_wdata[2:0];
		end
		status_nxt = status_nxt | st_set;
	end

	always @(posedge sys_clk) begin
		if (!rstn) begin
			ctrl_en_r <= `LSAG_CTRL_RST;
			status_r <= 3'h0;
			mask_r <= `LSAG_MASK_RST;
			count_r <= 32'h00000000;
			last_ea_r <= 32'h00000000;
			irq <= 1'b0;
			bus_rdata <= 32'h00000000;
		end else begin
			if (wr_ctrl) begin
				ctrl_en_r <= bus_wdata[`LSAG_CTRL_EN];
			end
			if (wr_mask) begin
				mask_r <= bus_wdata[2:0];
			end
			status_r <= status_nxt;
			irq <= |(status_nxt & mask_r);
			if (take) begin
				count_r <= count_r + 32'h00000001;
				last_ea_r <= ea_nxt;
			end
			bus_rdata <= 32'h00000000;
			if (bus_rd) begin
				case (bus_addr)
					`LSAG_REG_CTRL: bus_rdata <= {31'h00000000, ctrl_en_r};
					`LSAG_REG_STATUS: bus_rdata <= {29'h00000000, status_r};
					`LSAG_REG_MASK: bus_rdata <= {29'h00000000, mask_r};
					`LSAG_REG_COUNT: bus_rdata <= count_r;
					`LSAG_REG_LAST_EA: bus_rdata <= last_ea_r;
					default: bus_rdata <= 32'h00000000;
				endcase
			end
		end
	end

endmodule

// File: verification/lsag_assertions.sv
// concurrent checks on the address generator ports
`include "lsag_defs.vh"
module lsag_checker (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic req_valid,
	input wire logic [2:0] req_mode,
	input wire logic [2:0] req_size,
	input wire logic [17:0] req_imm,
	input wire logic [31:0] areg_even,
	input wire logic [31:0] areg_odd,
	input wire logic ans_valid,
	input wire logic [31:0] ans_addr,
	input wire logic ans_wb_en,
	input wire logic [31:0] ans_wb_data,
	input wire logic ans_trap_align,
	input wire logic ans_trap_seg,
	input wire logic bus_rd,
	input wire logic [31:0] bus_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	wire logic [31:0] off10 = {{22{req_imm[9]}}, req_imm[9:0]};
	a_answer_cause: assert property (ans_valid |-> $past(req_valid))
		else $error("answer without request");
	a_abs_layout: assert property (req_valid && req_mode == `LSAG_MODE_ABS ##1 ans_valid
		|-> ans_addr == {$past(req_imm[17:14]), 14'h0, $past(req_imm[13:0]), 4'h0} >> 4)
		else $error("absolute address wrong");
	a_short_sum: assert property (req_valid && req_mode == `LSAG_MODE_BSO ##1 ans_valid
		|-> ans_addr == $past(areg_even + off10) && !ans_wb_en)
		else $error("short offset address wrong");
	a_pre_update: assert property (req_valid && req_mode == `LSAG_MODE_PRE ##1 ans_valid
		&& !ans_trap_seg |-> ans_wb_en && ans_wb_data == ans_addr)
		else $error("pre-increment write-back wrong");
	a_post_update: assert property (req_valid && req_mode == `LSAG_MODE_POST ##1 ans_valid
		|-> ans_addr == $past(areg_even) && ans_wb_data == $past(areg_even + off10))
		else $error("post-increment wrong");
	a_circ_addr: assert property (req_valid && req_mode == `LSAG_MODE_CIRC ##1 ans_valid
		|-> ans_addr == $past(areg_even + {16'h0, areg_odd[15:0]}))
		else $error("circular address wrong");
	a_brev_addr: assert property (req_valid && req_mode == `LSAG_MODE_BREV ##1 ans_valid
		|-> ans_addr == $past(areg_even + {16'h0, areg_odd[15:0]}))
		else $error("bit-reverse address wrong");
	a_word_align: assert property (req_valid && req_mode == `LSAG_MODE_CIRC
		&& req_size == `LSAG_SIZE_WORD && areg_even[1:0] != 2'h0 ##1 ans_valid |-> ans_trap_align)
		else $error("misaligned base not trapped");
	a_trap_no_wb: assert property (ans_trap_align || ans_trap_seg |-> !ans_wb_en)
		else $error("write-back despite trap");
	a_rdata_idle: assert property (!bus_rd |=> bus_rdata == 32'h0)
		else $error("read data outside read answer");
endmodule
bind lsag_top lsag_checker i_chk (.sys_clk(sys_clk), .rstn(rstn), .req_valid(req_valid),
	.req_mode(req_mode), .req_size(req_size), .req_imm(req_imm), .areg_even(areg_even),
	.areg_odd(areg_odd), .ans_valid(ans_valid), .ans_addr(ans_addr), .ans_wb_en(ans_wb_en),
	.ans_wb_data(ans_wb_data), .ans_trap_align(ans_trap_align), .ans_trap_seg(ans_trap_seg),
	.bus_rd(bus_rd), .bus_rdata(bus_rdata));

// File: verification/lsag_core_model.sv
// model of the core's address register pair and its write-back commit
module lsag_core_model (
	input wire logic sys_clk,
	input wire logic wb_en,
	input wire logic wb_odd,
	input wire logic [31:0] wb_data,
	output logic [31:0] even_r,
	output logic [31:0] odd_r
);
	timeunit 1ns;
	timeprecision 1ps;
	// the core commits at the end of the answer cycle, so the next request sees it
	always @(posedge sys_clk) begin
		if (wb_en && wb_odd)
			odd_r <= wb_data;
		else if (wb_en)
			even_r <= wb_data;
	end
endmodule

// File: verification/lsag_top_tb.sv
// self-checking testbench for the address generator
`include "lsag_defs.vh"
module lsag_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0, rstn = 0, req_valid = 0, bus_wr = 0, bus_rd = 0;
	logic [2:0] req_mode = 0, req_size = 0;
	logic [17:0] req_imm = 0;
	logic [7:0] bus_addr = 0;
	logic [31:0] bus_wdata = 0, areg_even, areg_odd, ans_addr, ans_wrap_addr, ans_wb_data, bus_rdata;
	logic ans_valid, ans_split, ans_wb_en, ans_wb_odd, ans_trap_align, ans_trap_seg, irq;
	logic [3:0] ans_first_bytes;
	int error_cnt = 0, n_compared = 0;
	// index walk of a 50-byte halfword ring; offsets stay below the length
	logic [9:0] coff[4] = '{10'h002, 10'h004, 10'h3F8, 10'h004};
	logic [15:0] cidx[5] = '{16'd48, 16'd0, 16'd4, 16'd46, 16'd0};
	lsag_top i_dut (.sys_clk(sys_clk), .rstn(rstn), .req_valid(req_valid), .req_mode(req_mode),
		.req_size(req_size), .req_imm(req_imm), .areg_even(areg_even), .areg_odd(areg_odd),
		.ans_valid(ans_valid), .ans_addr(ans_addr), .ans_split(ans_split),
		.ans_wrap_addr(ans_wrap_addr), .ans_first_bytes(ans_first_bytes), .ans_wb_en(ans_wb_en),
		.ans_wb_odd(ans_wb_odd), .ans_wb_data(ans_wb_data), .ans_trap_align(ans_trap_align),
		.ans_trap_seg(ans_trap_seg), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq));
	lsag_core_model i_core (.sys_clk(sys_clk), .wb_en(ans_wb_en), .wb_odd(ans_wb_odd),
		.wb_data(ans_wb_data), .even_r(areg_even), .odd_r(areg_odd));
	initial forever #10 sys_clk = ~sys_clk;
	// ***************
	// tasks
	// ***************
	function automatic logic [15:0] rev16(input logic [15:0] v);
		for (int n = 0; n < 16; n++)
			rev16[n] = v[15 - n];
	endfunction
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1;
		chk(name, exp, bus_rdata);
	endtask
	// two edges so a pending write-back lands before the pair is overwritten
	task automatic ld(input logic [31:0] e, input logic [31:0] o);
		repeat (2) @(posedge sys_clk);
		i_core.even_r <= e;
		i_core.odd_r <= o;
	endtask
	task automatic rq(input logic [2:0] m, input logic [2:0] s, input logic [17:0] imm);
		@(posedge sys_clk);
		req_mode <= m;
		req_size <= s;
		req_imm <= imm;
		req_valid <= 1'b1;
		@(posedge sys_clk);
		req_valid <= 1'b0;
		#1;
	endtask
	// flags: valid, write-back, alignment trap, segment trap
	task automatic ex(input logic [31:0] a, input logic [3:0] f, input logic [31:0] wd);
		chk("addr", a, ans_addr);
		chk("flags", {28'h0, f}, {28'h0, ans_valid, ans_wb_en, ans_trap_align, ans_trap_seg});
		if (f[2])
			chk("wb_data", wd, ans_wb_data);
	endtask
	initial begin
		#100us;
		error_cnt++;
		report_and_stop();
	end
	// ***************
	// tests
	// ***************
	initial begin
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b1;
		rd(`LSAG_REG_CTRL, 32'h1, "ctrl");
		rd(`LSAG_REG_MASK, 32'h0, "mask");
		rq(`LSAG_MODE_ABS, `LSAG_SIZE_BIT, 18'h3ABCD);
		ex(32'hE0002BCD, 4'b1000, 0);
		ld(32'h10000100, 0);
		rq(`LSAG_MODE_BSO, `LSAG_SIZE_BYTE, 18'h003F0);
		ex(32'h100000F0, 4'b1000, 0);
		ld(32'h20010000, 0);
		rq(`LSAG_MODE_BLO, `LSAG_SIZE_DWORD, 18'h08000);
		ex(32'h20008000, 4'b1000, 0);
		ld(32'h10000000, 0);
		rq(`LSAG_MODE_PRE, `LSAG_SIZE_WORD, 18'h008);
		ex(32'h10000008, 4'b1100, 32'h10000008);
		rq(`LSAG_MODE_POST, `LSAG_SIZE_WORD, 18'h008);
		ex(32'h10000008, 4'b1100, 32'h10000010);
		chk("wb_odd_post", 32'h0, {31'h0, ans_wb_odd});
		ld(32'h10000000, 0);
		rq(`LSAG_MODE_PRE, `LSAG_SIZE_WORD, 18'h3FC);
		ex(32'h0FFFFFFC, 4'b1001, 0);
		ld(32'h200, {16'd50, 16'd48});
		for (int k = 0; k < 4; k++) begin
			rq(`LSAG_MODE_CIRC, `LSAG_SIZE_HALF, {8'h0, coff[k]});
			ex(32'h200 + cidx[k], 4'b1100, {16'd50, cidx[k + 1]});
		end
		ld(32'h200, {16'd52, 16'd50});
		rq(`LSAG_MODE_CIRC, `LSAG_SIZE_WORD, 18'h004);
		ex(32'h232, 4'b1100, {16'd52, 16'd2});
		chk("split", {31'h0, 1'b1}, {31'h0, ans_split});
		chk("first", 32'h2, {28'h0, ans_first_bytes});
		chk("wrap", 32'h200, ans_wrap_addr);
		chk("wb_odd_circ", 32'h1, {31'h0, ans_wb_odd});
		ld(32'h202, {16'd52, 16'd0});
		rq(`LSAG_MODE_CIRC, `LSAG_SIZE_WORD, 18'h0);
		ex(32'h202, 4'b1010, 0);
		ld(32'h200, {16'd50, 16'd0});
		rq(`LSAG_MODE_CIRC, `LSAG_SIZE_WORD, 18'h0);
		ex(32'h200, 4'b1010, 0);
		ld(32'h400, {16'hFFFF, 16'hC000});
		rq(`LSAG_MODE_BREV, `LSAG_SIZE_HALF, 18'h0);
		ex(32'hC400, 4'b1100,
			{16'hFFFF, rev16(rev16(16'hC000) + rev16(16'hFFFF))});
		rd(`LSAG_REG_STATUS, 32'h7, "status");
		rd(`LSAG_REG_COUNT, 32'hE, "count");
		rd(`LSAG_REG_LAST_EA, 32'hC400, "last_ea");
		rd(8'h40, 32'h0, "unmapped");
		wr(`LSAG_REG_MASK, 32'h2);
		repeat (2) @(posedge sys_clk);
		#1;
		chk("irq_set", 32'h1, {31'h0, irq});
		wr(`LSAG_REG_STATUS, 32'h2);
		repeat (2) @(posedge sys_clk);
		#1;
		chk("irq_clear", 32'h0, {31'h0, irq});
		rd(`LSAG_REG_STATUS, 32'h5, "status_w1c");
		wr(`LSAG_REG_CTRL, 32'h0);
		rq(`LSAG_MODE_ABS, `LSAG_SIZE_BYTE, 18'h1);
		chk("refused", 32'h0, {31'h0, ans_valid});
		wr(`LSAG_REG_CTRL, 32'h1);
		rd(`LSAG_REG_COUNT, 32'hE, "count_refused");
		// the spare mode code answers with address zero and writes back no address register
		rq(3'h7, `LSAG_SIZE_BYTE, 18'h3FFFF);
		ex(32'h0, 4'b1000, 0);
		// a reset in mid-run must bring enable, mask, status and count back to defaults
		wr(`LSAG_REG_CTRL, 32'h0);
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		rd(`LSAG_REG_CTRL, 32'h1, "ctrl_reset");
		rd(`LSAG_REG_MASK, 32'h0, "mask_reset");
		rd(`LSAG_REG_STATUS, 32'h0, "status_reset");
		rd(`LSAG_REG_COUNT, 32'h0, "count_reset");
		report_and_stop();
	end
endmodule
